/* File: design/thbi_pkg.sv */
// Package: constants and carriers for the timer host bus interface
`default_nettype none
package thbi_pkg;
   localparam int N_CNT = 5;
   // Data pointer layout: low 4 bits pick the target, value 4'hf is the mode register
   localparam logic [3:0] PTR_MODE     = 4'hf;
   localparam logic [3:0] PTR_CNT_BASE = 4'h0;   // Targets 0..4 are counter control words
   localparam logic [3:0] PTR_ALARM1   = 4'h5;
   localparam logic [3:0] PTR_ALARM2   = 4'h6;
   localparam logic [3:0] PTR_RELOAD0  = 4'h8;   // Targets 8..12 are reload values
   // Master mode word fields
   localparam int MODE_WIDTH_BIT = 14;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   // Counter control word fields
   localparam int CC_SRC_LSB   = 0;   // 3-bit source select, 0 means none
   localparam int CC_SRC_EDGE  = 3;   // 1 counts falling edge
   localparam int CC_OUT_POL   = 4;   // 1 inverts waveform
   localparam int CC_ALARM_OUT = 5;   // Alarm output mode, counters 1 and 2
   localparam int CC_TOGGLE    = 6;   // 1 toggle output, 0 pulse
   localparam int CC_GATE_EN   = 7;   // Gating enable
   localparam logic [15:0] CC_RESET     = 16'h0000;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   localparam logic [7:0]  CMD_RESET    = 8'hff;  // Software reset command
   localparam int DIVIDED_FREQUENCY_PIN_SRC_LSB = 8;   // Mode bits 10:8 pick divider source

   typedef struct packed {
      logic       csn;
      logic       rdn;
      logic       wrn;
      logic       ctl;
   } thbi_strobe_t;

   typedef struct packed {
      logic [15:0] dout;
      logic [15:0] oe;
   } thbi_drive_t;
endpackage : thbi_pkg
`default_nettype wire

/* File: design/thbi_top.sv */
// Host bus port, register file and counter outputs of the timer
`default_nettype none
// Function
// R1: Any source line feeds any counter, divider
// R2: Source edge polarity chosen per counter
// R3: One tristate output per counter, own polarity
// R4: Terminal-count event forms output waveform
// R5: Counters 1,2 may output alarm match
// R6: Data lines in on write, out on read
// R7: Chip select inactive releases all data lines
// R8: Reset leaves bus eight bits wide
// R9: Width bit set by eight-bit command write (code sets it by a data write to the mode register)
// R10: Sixteen-bit mode uses all data lines
// R11: Eight-bit mode never drives upper lines
// R12: Lines 8-12 are gate disables in 8-bit
// R13: Host holds lines 13-15 high writing
// R14: Strobes ignored while chip select high
// R15: First chip select clears power-on reset
// R16: Host issues reset if select tied low
// R17: Read source from port and pointer
// R18: Write target from port and pointer
// R19: Host never asserts both strobes
// R20: Control write loads command and pointer
// R21: Control read returns status
// R22: Data port reaches other registers indirectly
// R23: Gate disable only in 8-bit mode
// R24: Strobes synchronised, one access each
module thbi_top
   import thbi_pkg::*;
(
   input  wire logic              CLOCK_IN,
   input  wire logic              RESETN_IN,
   input  wire logic              CSN_IN,
   input  wire logic              RDN_IN,
   input  wire logic              WRN_IN,
   input  wire logic              CTL_SEL_IN,
   input  wire logic [15:0]       HOST_DATA_LINES_IN,
   output logic [15:0]            HOST_DATA_LINES_OUT,
   output logic [15:0]            HOST_DATA_LINES_OE_OUT,
   input  wire logic [N_CNT-1:0]  COUNT_INPUT_LINES_IN,
   input  wire logic [N_CNT-1:0]  GATE_IN,
   output logic [N_CNT-1:0]       COUNTER_WAVEFORM_PINS_OUT,
   output logic [N_CNT-1:0]       COUNTER_WAVEFORM_PINS_OE_OUT,
   output logic                   DIVIDED_FREQUENCY_PIN_OUT,
   output logic                   POR_PENDING_OUT
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [3:0]  s1, s2, s3;
   logic [15:0] d1, d2, d3;
   logic [N_CNT-1:0] c1, c2, c3;
   thbi_strobe_t st;

   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         s1 <= 4'hf; s2 <= 4'hf; s3 <= 4'hf;
         d1 <= 16'hffff; d2 <= 16'hffff; d3 <= 16'hffff;
         c1 <= '0; c2 <= '0; c3 <= '0;
      end else begin
         s1 <= {CSN_IN, RDN_IN, WRN_IN, CTL_SEL_IN};
         s2 <= s1;
         s3 <= s2;
         d1 <= HOST_DATA_LINES_IN;
         d2 <= d1;
         d3 <= d2;
         c1 <= COUNT_INPUT_LINES_IN;
         c2 <= c1;
         c3 <= c2;
      end
   end

   // Accepted strobe state changes only when second and third stages agree
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         st <= '{csn: 1'b1, rdn: 1'b1, wrn: 1'b1, ctl: 1'b1};
      end else begin
         if (s2[3] == s3[3]) st.csn <= s3[3];
         if (s2[2] == s3[2]) st.rdn <= s3[2];
         if (s2[1] == s3[1]) st.wrn <= s3[1];
         if (s2[0] == s3[0]) st.ctl <= s3[0];
      end
   end

   // ----------------------------------------
   // Access decode
   // ----------------------------------------
   logic wr_act, rd_act, wr_prev, wr_pulse;
   // R14: select gates strobes
   assign wr_act = !st.csn && !st.wrn;
   assign rd_act = !st.csn && !st.rdn && st.wrn;

   // R24: one write per strobe
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) wr_prev <= 1'b0;
      else            wr_prev <= wr_act;
   end
   assign wr_pulse = wr_act && !wr_prev;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic        por;
   logic [7:0]  cmd;
   logic [3:0]  ptr;
   logic [15:0] mode;
   logic [15:0] cc  [N_CNT];
   logic [15:0] rld [N_CNT];
   logic [15:0] cnt [N_CNT];
   logic [15:0] alarm [2];
   logic        wide, soft_rst;
   logic [15:0] wdata;

   assign wide = mode[MODE_WIDTH_BIT];
   // R10: all lines in wide mode
   assign wdata = wide ? d3 : {8'h00, d3[7:0]};
   assign soft_rst = wr_pulse && st.ctl && d3[7:0] == CMD_RESET;

   // R15: first select clears power-on
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN)      por <= 1'b1;
      else if (!st.csn)    por <= 1'b0;
   end
   assign POR_PENDING_OUT = por;

   // R20: control write loads command
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         cmd <= 8'h00;
         ptr <= 4'h0;
      end else if (wr_pulse && st.ctl) begin
         cmd <= d3[7:0];
         ptr <= d3[3:0];
      end
   end

   // R9: width bit via data write
   // R8: reset returns to narrow bus
   // R18: write target from pointer
   // R22: indirect data port
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         mode <= MODE_RESET;
      end else if (por || soft_rst) begin
         mode <= MODE_RESET;
      end else if (wr_pulse && !st.ctl && ptr == PTR_MODE) begin
         mode <= wide ? wdata : {d3[15:13] == 3'b111 ? d3[7:0] : mode[15:8], d3[7:0]};
      end
   end

   // ----------------------------------------
   // Counters
   // ----------------------------------------
   logic [N_CNT-1:0] tc, wave, src_sel, c_prev, gate_ok;

   function automatic logic pick_src(input logic [2:0] sel, input logic [N_CNT-1:0] lines);
      pick_src = (sel != 3'd0 && sel <= 3'(N_CNT)) ? lines[sel - 3'd1] : 1'b0;
   endfunction : pick_src

   // Previous source levels, same selection on both sides of the edge
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) c_prev <= '0;
      else            c_prev <= c3;
   end

   genvar g;
   generate
      for (g = 0; g < N_CNT; g++) begin : g_cnt
         logic edge_hit;
         // R1: any line to any counter
         // R2: per-counter edge polarity
         assign src_sel[g] = pick_src(cc[g][CC_SRC_LSB +: 3], c3) ^ cc[g][CC_SRC_EDGE];
         assign edge_hit = src_sel[g] &&
                           !(pick_src(cc[g][CC_SRC_LSB +: 3], c_prev) ^ cc[g][CC_SRC_EDGE]);
         // R23: aux disable only narrow
         // R12: low line blocks gated counting
         assign gate_ok[g] = !cc[g][CC_GATE_EN] || (GATE_IN[g] && (wide || d3[8 + g]));
         // R4: would-be-zero detect
         assign tc[g] = edge_hit && gate_ok[g] && cnt[g] == 16'h0001;

         always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
            if (!RESETN_IN) begin
               cc[g]  <= CC_RESET;
               rld[g] <= RELOAD_RESET;
               cnt[g] <= 16'h0000;
               wave[g] <= 1'b0;
            end else if (por || soft_rst) begin
               cc[g]  <= CC_RESET;
               rld[g] <= RELOAD_RESET;
               cnt[g] <= 16'h0000;
               wave[g] <= 1'b0;
            end else begin
               if (wr_pulse && !st.ctl && ptr == PTR_CNT_BASE + 4'(g)) cc[g] <= wdata;
               if (wr_pulse && !st.ctl && ptr == PTR_RELOAD0 + 4'(g)) begin
                  rld[g] <= wdata;
                  cnt[g] <= wdata;
               end else if (tc[g]) begin
                  cnt[g] <= rld[g];
               end else if (edge_hit && gate_ok[g]) begin
                  cnt[g] <= cnt[g] - 16'h0001;
               end
               if (tc[g]) wave[g] <= cc[g][CC_TOGGLE] ? !wave[g] : 1'b1;
               else if (!cc[g][CC_TOGGLE]) wave[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Alarm registers
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         alarm[0] <= RELOAD_RESET;
         alarm[1] <= RELOAD_RESET;
      end else if (wr_pulse && !st.ctl) begin
         if (ptr == PTR_ALARM1) alarm[0] <= wdata;
         if (ptr == PTR_ALARM2) alarm[1] <= wdata;
      end
   end

   // R3: own counter, own polarity
   // R5: alarm override counters 1,2
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         COUNTER_WAVEFORM_PINS_OUT <= '0;
      end else begin
         for (int i = 0; i < N_CNT; i++) begin
            if (i < 2 && cc[i][CC_ALARM_OUT])
               COUNTER_WAVEFORM_PINS_OUT[i] <= (cnt[i] == alarm[i]) ^ cc[i][CC_OUT_POL];
            else
               COUNTER_WAVEFORM_PINS_OUT[i] <= wave[i] ^ cc[i][CC_OUT_POL];
         end
      end
   end
   // Output enabled once its counter's source select is nonzero
   always_comb begin
      for (int i = 0; i < N_CNT; i++)
         COUNTER_WAVEFORM_PINS_OE_OUT[i] = cc[i][CC_SRC_LSB +: 3] != 3'd0;
   end

   // R1: line routed to divider
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) DIVIDED_FREQUENCY_PIN_OUT <= 1'b0;
      else DIVIDED_FREQUENCY_PIN_OUT <= pick_src(mode[DIVIDED_FREQUENCY_PIN_SRC_LSB +: 3], c3);
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [15:0] rsel, status;
   assign status = {8'h00, 3'b000, COUNTER_WAVEFORM_PINS_OUT};

   // R21: control read gives status
   // R17: read source by pointer
   always_comb begin
      rsel = 16'h0000;
      if (st.ctl) rsel = status;
      else if (ptr == PTR_MODE) rsel = mode;
      else if (ptr == PTR_ALARM1) rsel = alarm[0];
      else if (ptr == PTR_ALARM2) rsel = alarm[1];
      else if (ptr < 4'(N_CNT)) rsel = cc[ptr[2:0]];
      else if (ptr >= PTR_RELOAD0 && ptr < PTR_RELOAD0 + 4'(N_CNT))
         rsel = cnt[3'(ptr - PTR_RELOAD0)];
   end

   // R6: drive only on read
   // R7: release when deselected
   // R11: upper lines never driven narrow
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         HOST_DATA_LINES_OUT    <= 16'h0000;
         HOST_DATA_LINES_OE_OUT <= 16'h0000;
      end else begin
         HOST_DATA_LINES_OUT    <= wide ? rsel : {8'h00, rsel[7:0]};
         HOST_DATA_LINES_OE_OUT <= rd_act ? (wide ? 16'hffff : 16'h00ff) : 16'h0000;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_narrow_upper_quiet: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN) // R11
      !$past(wide) |-> HOST_DATA_LINES_OE_OUT[15:8] == 8'h00)
      else $error("upper lines driven in narrow mode");
   a_deselect_release: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN) // R7
      st.csn |=> HOST_DATA_LINES_OE_OUT == 16'h0000)
      else $error("lines driven while deselected");
   a_read_drives: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN) // R6
      rd_act |=> HOST_DATA_LINES_OE_OUT[7:0] == 8'hff)
      else $error("read not driven");
   a_ctl_write_ptr: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN) // R20
      wr_pulse && st.ctl |=> ptr == $past(d3[3:0]))
      else $error("pointer not loaded");
   a_single_write: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN) // R24
      wr_pulse |=> !wr_pulse)
      else $error("double write");
   a_por_cleared: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN) // R15
      !st.csn |=> !por)
      else $error("power-on not cleared");
   a_status_read: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN) // R21
      rd_act && st.ctl |=> HOST_DATA_LINES_OUT[4:0] == $past(status[4:0]))
      else $error("status not returned");
   a_por_narrow: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN) // R8
      por |=> !wide)
      else $error("wide during power-on");
endmodule : thbi_top
`default_nettype wire

/* File: tb/thbi_host_model.sv */
// Host processor model for the timer bus
`default_nettype none
module thbi_host_model (
   input  wire logic        clk_in,
   input  wire logic [15:0] dev_data_in,
   input  wire logic [15:0] dev_oe_in,
   output logic             csn_out,
   output logic             rdn_out,
   output logic             wrn_out,
   output logic             ctl_out,
   output logic [15:0]      bus_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] hv;
   // Wire level from both parties
   assign bus_out = (dev_oe_in & dev_data_in) | (~dev_oe_in & hv);
   initial begin
      csn_out = 1'b1;
      rdn_out = 1'b1;
      wrn_out = 1'b1;
      ctl_out = 1'b0;
      hv = 16'hffff;
   end
   task automatic wr(input logic cs_n, input logic c, input logic [15:0] d);
      @(negedge clk_in);
      csn_out = cs_n;
      ctl_out = c;
      hv = d;
      wrn_out = 1'b0;
      repeat (8) @(negedge clk_in);
      wrn_out = 1'b1;
      csn_out = 1'b1;
      repeat (8) @(negedge clk_in);
   endtask : wr
   task automatic rd(input logic cs_n, input logic c, output logic [15:0] q,
                     output logic [15:0] oe);
      @(negedge clk_in);
      csn_out = cs_n;
      ctl_out = c;
      // Released lines show inverse
      hv = ~hv;
      rdn_out = 1'b0;
      repeat (8) @(negedge clk_in);
      q = bus_out & dev_oe_in;
      oe = dev_oe_in;
      rdn_out = 1'b1;
      csn_out = 1'b1;
      repeat (8) @(negedge clk_in);
   endtask : rd
endmodule : thbi_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the timer host bus interface
`default_nettype none
module tb_top
   import thbi_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic             clock = 1'b0;
   logic             resetn = 1'b0;
   logic             csn, rdn, wrn, ctl, fpin, por;
   logic [15:0]      bus, dout, doe, q, oe;
   logic [N_CNT-1:0] src = 5'h00;
   logic [N_CNT-1:0] gate = 5'h1f;
   logic [N_CNT-1:0] pins, pins_oe;
   int               error_cnt = 0;
   int               n_compared = 0;
   thbi_top u_dut (
      .CLOCK_IN                     (clock),
      .RESETN_IN                    (resetn),
      .CSN_IN                       (csn),
      .RDN_IN                       (rdn),
      .WRN_IN                       (wrn),
      .CTL_SEL_IN                   (ctl),
      .HOST_DATA_LINES_IN           (bus),
      .HOST_DATA_LINES_OUT          (dout),
      .HOST_DATA_LINES_OE_OUT       (doe),
      .COUNT_INPUT_LINES_IN         (src),
      .GATE_IN                      (gate),
      .COUNTER_WAVEFORM_PINS_OUT    (pins),
      .COUNTER_WAVEFORM_PINS_OE_OUT (pins_oe),
      .DIVIDED_FREQUENCY_PIN_OUT    (fpin),
      .POR_PENDING_OUT              (por)
   );
   thbi_host_model u_host (
      .clk_in      (clock),
      .dev_data_in (dout),
      .dev_oe_in   (doe),
      .csn_out     (csn),
      .rdn_out     (rdn),
      .wrn_out     (wrn),
      .ctl_out     (ctl),
      .bus_out     (bus)
   );
   // ---------------------------
   // Clock, reset, report tasks
   // ---------------------------
   initial begin
      forever #5 clock = ~clock;
   end
   initial begin
      repeat (5) @(negedge clock);
      resetn = 1'b1;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tend(input string s);
      $display("Test %s done", s);
   endtask : tend
   task automatic pulse(input int n);
      repeat (n) begin
         src = 5'h01;
         repeat (8) @(negedge clock);
         src = 5'h00;
         repeat (8) @(negedge clock);
      end
   endtask : pulse
   task automatic summarize;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (5000) @(posedge clock);
      error_cnt++;
      $display("[FAIL] %0t watchdog expired", $time);
      summarize();
   end
   // ---------------------------
   // Test sequence
   // ---------------------------
   initial begin
      repeat (8) @(negedge clock);
      chk({15'h0000, por}, 16'h0001);
      chk(doe, 16'h0000);
      u_host.rd(1'b0, 1'b1, q, oe);
      chk({15'h0000, por}, 16'h0000);
      tend("power_on");
      u_host.wr(1'b0, 1'b1, 16'hff00);
      u_host.wr(1'b0, 1'b0, 16'hff01);
      u_host.wr(1'b0, 1'b1, 16'hff01);
      u_host.wr(1'b0, 1'b0, 16'hff12);
      chk({11'h000, pins_oe}, 16'h0003);
      chk({11'h000, pins}, 16'h0002);
      u_host.rd(1'b0, 1'b1, q, oe);
      chk(q, 16'h0002);
      chk(oe, 16'h00ff);
      tend("status");
      u_host.wr(1'b0, 1'b1, 16'hff08);
      u_host.wr(1'b0, 1'b0, 16'hff5c);
      u_host.rd(1'b0, 1'b0, q, oe);
      chk(q, 16'h005c);
      u_host.wr(1'b1, 1'b0, 16'hffa7);
      u_host.rd(1'b1, 1'b0, q, oe);
      chk(oe, 16'h0000);
      u_host.rd(1'b0, 1'b0, q, oe);
      chk(q, 16'h005c);
      tend("indirect");
      u_host.wr(1'b0, 1'b1, 16'hff0f);
      u_host.wr(1'b0, 1'b0, 16'hff40);
      u_host.rd(1'b0, 1'b0, q, oe);
      chk(oe, 16'hffff);
      chk(q, 16'h4040);
      u_host.wr(1'b0, 1'b0, 16'h4100);
      @(negedge clock);
      src = 5'h01;
      repeat (8) @(negedge clock);
      chk({15'h0000, fpin}, 16'h0001);
      src = 5'h00;
      repeat (8) @(negedge clock);
      chk({15'h0000, fpin}, 16'h0000);
      u_host.wr(1'b0, 1'b1, 16'h0009);
      u_host.wr(1'b0, 1'b0, 16'h1234);
      u_host.rd(1'b0, 1'b0, q, oe);
      chk(q, 16'h1234);
      tend("wide_bus");
      u_host.wr(1'b0, 1'b1, 16'h00ff);
      u_host.wr(1'b0, 1'b1, 16'hff09);
      u_host.rd(1'b0, 1'b0, q, oe);
      chk(oe, 16'h00ff);
      chk(q, 16'h0000);
      chk({11'h000, pins_oe}, 16'h0000);
      tend("soft_reset");
      u_host.wr(1'b0, 1'b1, 16'hff08);
      u_host.wr(1'b0, 1'b0, 16'hff02);
      u_host.wr(1'b0, 1'b1, 16'hff00);
      u_host.wr(1'b0, 1'b0, 16'hff49);
      pulse(1);
      src = 5'h01;
      repeat (8) @(negedge clock);
      chk({15'h0000, pins[0]}, 16'h0000);
      src = 5'h00;
      repeat (8) @(negedge clock);
      chk({15'h0000, pins[0]}, 16'h0001);
      u_host.wr(1'b0, 1'b0, 16'he0c9);
      pulse(2);
      chk({15'h0000, pins[0]}, 16'h0001);
      u_host.wr(1'b0, 1'b0, 16'hffc9);
      pulse(2);
      chk({15'h0000, pins[0]}, 16'h0000);
      u_host.wr(1'b0, 1'b1, 16'hff0f);
      u_host.wr(1'b0, 1'b0, 16'hff40);
      u_host.wr(1'b0, 1'b1, 16'h0000);
      pulse(2);
      chk({15'h0000, pins[0]}, 16'h0001);
      tend("counting");
      u_host.wr(1'b0, 1'b1, 16'h0005);
      u_host.wr(1'b0, 1'b0, 16'h0002);
      u_host.wr(1'b0, 1'b1, 16'h0000);
      u_host.wr(1'b0, 1'b0, 16'h00e9);
      chk({15'h0000, pins[0]}, 16'h0001);
      pulse(1);
      chk({15'h0000, pins[0]}, 16'h0000);
      tend("alarm");
      summarize();
   end
endmodule : tb_top
`default_nettype wire
